// ===== hdl/mtr_regs.sv
// mtr_regs: serial register bank, energy accumulators and irq pin.
// assumes: power samples and events come from logic on clk;
// sclk, cs_n and din are asynchronous pins.
`timescale 1ns/10ps
`default_nettype none
module mtr_regs
    import mtr_pkg::*;
#(
    parameter int PWR_W    = 16,
    parameter int ACC_FRAC = 8
) (
    input  wire logic                          clk,
    input  wire logic                          resetn,
    input  wire logic                          clk_en,
    input  wire logic                          sclk,
    input  wire logic                          cs_n,
    input  wire logic                          din,
    output var  logic                          dout,
    output var  logic                          dout_oe,
    output var  logic                          irq_n,
    output var  logic                          irq_oe,
    input  wire logic                          sample_valid,
    input  wire logic [PHASES-1:0][PWR_W-1:0]  active_power,
    input  wire logic [PHASES-1:0][PWR_W-1:0]  apparent_power,
    input  wire logic                          half_cycle_tick,
    input  wire logic [STATUS_W-1:0]           irq_event
);

    localparam int ACC_W = REG_W + ACC_FRAC;

    mtr_ser_if ser ();

    // serial pins and command framing live in the engine
    mtr_serial u_serial (
        .clk     (clk),
        .resetn  (resetn),
        .clk_en  (clk_en),
        .sclk    (sclk),
        .cs_n    (cs_n),
        .din     (din),
        .dout    (dout),
        .dout_oe (dout_oe),
        .ifc     (ser.engine)
    );

    logic signed [ACC_W-1:0]   ae_acc_reg;
    logic signed [ACC_W-1:0]   line_acc_reg;
    logic signed [ACC_W-1:0]   va_acc_reg;
    logic [REG_W-1:0]          line_ae_reg;
    logic [15:0]               half_cnt_reg;
    logic [15:0]               half_cyc_reg;
    logic [BYTE_W-1:0]         ae_mode_reg;
    logic [BYTE_W-1:0]         va_mode_reg;
    logic [STATUS_W-1:0]       irq_en_reg;
    logic [STATUS_W-1:0]       status_reg;
    logic                      irq_hold_reg;

    // combine phases: field low bits enable phases, upper bits scale
    function automatic logic signed [ACC_W-1:0] phase_sum(
        input logic [MODE_TOTAL_W-1:0]         sel,
        input logic [PHASES-1:0][PWR_W-1:0]    p
    );
        logic signed [ACC_W-1:0] s;
        s = '0;
        for (int i = 0; i < PHASES; i++) begin
            if (sel[i]) begin
                s = s + ACC_W'($signed(p[i]));
            end
        end
        return s >>> sel[MODE_TOTAL_W-1:MODE_SHIFT_LSB];
    endfunction : phase_sum

    // register width in bytes; unmapped reads as one zero byte
    function automatic logic [LEN_W-1:0] reg_bytes(
        input logic [CMD_ADDR_W-1:0] a
    );
        logic [LEN_W-1:0] n;
        n = LEN_1;
        if (a == ADDR_AE_TOTAL || a == ADDR_AE_RC || a == ADDR_LINE_AE
            || a == ADDR_VA_TOTAL) begin
            n = LEN_3;
        end else if (a == ADDR_IRQ_EN || a == ADDR_STATUS
                     || a == ADDR_STATUS_RC || a == ADDR_HALF_CYC) begin
            n = LEN_2;
        end
        return n;
    endfunction : reg_bytes

    // command decode
    // six-bit register address
    wire [CMD_ADDR_W-1:0] cmd_addr  = ser.cmd_byte[CMD_ADDR_W-1:0];
    wire                  cmd_write = ser.cmd_byte[CMD_DIR_BIT];
    wire [REG_W-1:0]      ae_view   = ae_acc_reg[ACC_W-1:ACC_FRAC];
    wire [REG_W-1:0]      va_view   = va_acc_reg[ACC_W-1:ACC_FRAC];

    // read mux, right justified in the low bits
    // total view at 01h
    assign ser.reg_len = reg_bytes(cmd_addr);
    assign ser.rd_word =
        (cmd_addr == ADDR_AE_TOTAL)  ? ae_view :
        (cmd_addr == ADDR_AE_RC)     ? ae_view :
        (cmd_addr == ADDR_LINE_AE)   ? line_ae_reg :
        (cmd_addr == ADDR_VA_TOTAL)  ? va_view :
        (cmd_addr == ADDR_AE_MODE)   ? REG_W'(ae_mode_reg) :
        (cmd_addr == ADDR_VA_MODE)   ? REG_W'(va_mode_reg) :
        (cmd_addr == ADDR_IRQ_EN)    ? REG_W'(irq_en_reg) :
        (cmd_addr == ADDR_STATUS)    ? REG_W'(status_reg) :
        (cmd_addr == ADDR_STATUS_RC) ? REG_W'(status_reg) :
        (cmd_addr == ADDR_HALF_CYC)  ? REG_W'(half_cyc_reg) :
        '0;

    // read side effects and write targets
    wire ae_clear   = ser.rd_take & (cmd_addr == ADDR_AE_RC);
    wire stat_clear = ser.rd_take & (cmd_addr == ADDR_STATUS_RC);
    wire wr_hit_ae  = ser.wr_strobe & (cmd_addr == ADDR_AE_MODE);
    wire wr_hit_va  = ser.wr_strobe & (cmd_addr == ADDR_VA_MODE);
    wire wr_hit_en  = ser.wr_strobe & (cmd_addr == ADDR_IRQ_EN);
    wire wr_hit_hc  = ser.wr_strobe & (cmd_addr == ADDR_HALF_CYC);

    // per-sample contributions
    // total field of active mode
    wire signed [ACC_W-1:0] ae_inc = phase_sum(
        ae_mode_reg[MODE_TOTAL_LSB +: MODE_TOTAL_W], active_power);
    // line field: phase enables only, no scaling
    wire signed [ACC_W-1:0] line_inc = phase_sum(
        MODE_TOTAL_W'(ae_mode_reg[MODE_LINE_LSB +: MODE_LINE_W]),
        active_power);
    wire signed [ACC_W-1:0] va_inc = phase_sum(
        va_mode_reg[MODE_TOTAL_LSB +: MODE_TOTAL_W], apparent_power);

    wire [15:0] half_target = (half_cyc_reg == '0) ? 16'h0001
                                                   : half_cyc_reg;
    wire        line_close  = half_cycle_tick
                              & (half_cnt_reg + 16'h0001 >= half_target);

    // configuration registers; writes to read-only addresses drop
    // address zero matches no target
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ae_mode_reg  <= AE_MODE_RST;
            va_mode_reg  <= VA_MODE_RST;
            irq_en_reg   <= IRQ_EN_RST;
            half_cyc_reg <= HALF_CYC_RST;
        end else if (clk_en) begin
            if (wr_hit_ae) ae_mode_reg  <= ser.wr_word[BYTE_W-1:0];
            if (wr_hit_va) va_mode_reg  <= ser.wr_word[BYTE_W-1:0];
            if (wr_hit_en) irq_en_reg   <= ser.wr_word[STATUS_W-1:0];
            if (wr_hit_hc) half_cyc_reg <= ser.wr_word[15:0];
        end
    end

    // total accumulators; a sample landing on a clear is kept
    // ACC_FRAC extra low bits hold the fraction below the register view
    // plain adders wrap in two's complement
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ae_acc_reg <= '0;
            va_acc_reg <= '0;
        end else if (clk_en) begin
            // read at 02h restarts the total
            if (ae_clear) begin
                ae_acc_reg <= sample_valid ? ae_inc : '0;
            end else if (sample_valid) begin
                ae_acc_reg <= ae_acc_reg + ae_inc;
            end
            if (sample_valid) begin
                va_acc_reg <= va_acc_reg + va_inc;
            end
        end
    end

    // line-cycle accumulation, latched every programmed half cycles
    // window closes on the counted tick
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            line_acc_reg <= '0;
            line_ae_reg  <= '0;
            half_cnt_reg <= '0;
        end else if (clk_en) begin
            if (line_close) begin
                line_ae_reg  <= REG_W'((line_acc_reg
                                + (sample_valid ? line_inc : '0))
                                >>> ACC_FRAC);
                line_acc_reg <= '0;
                half_cnt_reg <= '0;
            end else begin
                if (sample_valid) line_acc_reg <= line_acc_reg + line_inc;
                if (half_cycle_tick) half_cnt_reg <= half_cnt_reg + 16'h0001;
            end
            // new count takes effect from a fresh window
            if (wr_hit_hc) begin
                half_cnt_reg <= '0;
            end
        end
    end

    // status flags: a set always beats the read clear
    // flags set regardless of the enable mask
    // read at 11h clears all flags
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status_reg <= '0;
        end else if (clk_en) begin
            status_reg <= (stat_clear ? '0 : status_reg) | irq_event;
        end
    end

    // irq hold window around a read-clear status access
    wire hold_start = ser.cmd_strobe & ~cmd_write
                      & (ser.cmd_byte[CMD_ADDR_W-1:0] == ADDR_STATUS_RC);
    // release at the command's last falling edge
    // hold until the data phase ends or aborts
    wire irq_hold_next = hold_start | (irq_hold_reg & ~ser.xfer_end);
    wire irq_pending   = |(status_reg & irq_en_reg);
    // enabled pending flag pulls the pin
    // re-asserts after the data only if still pending
    wire irq_drive     = irq_pending & ~irq_hold_next;

    // open-drain pin: data low, enable high while pulling
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_hold_reg <= 1'b0;
            irq_n        <= 1'b1;
            irq_oe       <= 1'b0;
        end else if (clk_en) begin
            irq_hold_reg <= irq_hold_next;
            irq_n        <= ~irq_drive;
            irq_oe       <= irq_drive;
        end
    end

endmodule : mtr_regs
`default_nettype wire

// ===== hdl/mtr_pkg.sv
// mtr_pkg: constants shared by the metering register front end.
// assumes: included before the interface and both modules.
package mtr_pkg;

    // serial framing, status width and phase count
    localparam int BYTE_W      = 8;
    localparam int REG_W       = 24;
    localparam int CMD_DIR_BIT = 7;
    localparam int CMD_ADDR_W  = 6;
    localparam int BITCNT_W    = 5;
    localparam int LEN_W       = 2;
    localparam int STATUS_W    = 16;
    localparam int PHASES      = 3;

    // register addresses
    localparam logic [CMD_ADDR_W-1:0] ADDR_RESERVED  = 6'h00;
    localparam logic [CMD_ADDR_W-1:0] ADDR_AE_TOTAL  = 6'h01;
    localparam logic [CMD_ADDR_W-1:0] ADDR_AE_RC     = 6'h02;
    localparam logic [CMD_ADDR_W-1:0] ADDR_LINE_AE   = 6'h03;
    localparam logic [CMD_ADDR_W-1:0] ADDR_VA_TOTAL  = 6'h04;
    localparam logic [CMD_ADDR_W-1:0] ADDR_AE_MODE   = 6'h0d;
    localparam logic [CMD_ADDR_W-1:0] ADDR_VA_MODE   = 6'h0e;
    localparam logic [CMD_ADDR_W-1:0] ADDR_IRQ_EN    = 6'h0f;
    localparam logic [CMD_ADDR_W-1:0] ADDR_STATUS    = 6'h10;
    localparam logic [CMD_ADDR_W-1:0] ADDR_STATUS_RC = 6'h11;
    localparam logic [CMD_ADDR_W-1:0] ADDR_HALF_CYC  = 6'h13;

    // transfer lengths in bytes
    localparam logic [LEN_W-1:0] LEN_1 = 2'h1;
    localparam logic [LEN_W-1:0] LEN_2 = 2'h2;
    localparam logic [LEN_W-1:0] LEN_3 = 2'h3;

    // reset values
    localparam logic [BYTE_W-1:0]   AE_MODE_RST  = 8'h3f;
    localparam logic [BYTE_W-1:0]   VA_MODE_RST  = 8'h3f;
    localparam logic [STATUS_W-1:0] IRQ_EN_RST   = 16'h0000;
    localparam logic [15:0]         HALF_CYC_RST = 16'h0064;

    // mode register fields
    localparam int MODE_TOTAL_LSB = 3;
    localparam int MODE_TOTAL_W   = 5;
    localparam int MODE_LINE_LSB  = 0;
    localparam int MODE_LINE_W    = 3;
    localparam int MODE_SHIFT_LSB = 3;

endpackage : mtr_pkg

// ===== hdl/mtr_ser_if.sv
// mtr_ser_if: carries decoded transfers between serial engine and regs.
// assumes: both ends run on the same clk and clock enable.
`timescale 1ns/10ps
`default_nettype none
interface mtr_ser_if;
    import mtr_pkg::*;
    logic [BYTE_W-1:0] cmd_byte;   // last command byte, held
    logic              cmd_strobe; // pulse at command's last bit
    logic [REG_W-1:0]  rd_word;    // right-justified read value
    logic [LEN_W-1:0]  reg_len;    // byte count of addressed register
    logic              rd_take;    // pulse, read value captured
    logic [REG_W-1:0]  wr_word;    // right-justified write value
    logic              wr_strobe;  // pulse, complete write
    logic              xfer_end;   // pulse, data phase over or aborted

    modport engine (output cmd_byte, cmd_strobe, rd_take, wr_word,
                    wr_strobe, xfer_end, input rd_word, reg_len);
    modport regs   (input cmd_byte, cmd_strobe, rd_take, wr_word,
                    wr_strobe, xfer_end, output rd_word, reg_len);
endinterface : mtr_ser_if
`default_nettype wire

// ===== hdl/mtr_serial.sv
// mtr_serial: pin synchronisers and serial shift engine.
// assumes: sclk is far slower than clk; clk_en gates all state.
`timescale 1ns/10ps
`default_nettype none
module mtr_serial
    import mtr_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  resetn,
    input  wire logic  clk_en,
    input  wire logic  sclk,
    input  wire logic  cs_n,
    input  wire logic  din,
    output var  logic  dout,
    output var  logic  dout_oe,
    mtr_ser_if.engine  ifc
);

    typedef enum logic [3:0] {
        ST_CMD  = 4'b0001,
        ST_LOAD = 4'b0010,
        ST_RD   = 4'b0100,
        ST_WR   = 4'b1000
    } mtr_st_t;

    mtr_st_t               state_reg;
    logic [2:0]            sclk_reg;  // [0],[1] sync, [2] edge history
    logic [1:0]            cs_reg;
    logic [1:0]            din_reg;
    logic [BITCNT_W-1:0]   cnt_reg;
    logic [BITCNT_W-1:0]   nbits_reg;
    logic [REG_W-1:0]      sh_reg;

    // edge detection reads only the second and third stages
    wire sclk_fall = sclk_reg[2] & ~sclk_reg[1];
    wire sclk_rise = ~sclk_reg[2] & sclk_reg[1];
    wire selected  = ~cs_reg[1];
    wire bit_in    = din_reg[1];
    wire [REG_W-1:0] sh_in = {sh_reg[REG_W-2:0], bit_in};
    wire last_bit  = (cnt_reg == nbits_reg - BITCNT_W'(1));

    // synchronisers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sclk_reg <= '1;  // idle high, so no false edge after reset
            cs_reg   <= '1;
            din_reg  <= '0;
        end else if (clk_en) begin
            sclk_reg <= {sclk_reg[1:0], sclk};
            cs_reg   <= {cs_reg[0], cs_n};
            din_reg  <= {din_reg[0], din};
        end
    end

    // shift engine; any deselect drops back to command mode
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg      <= ST_CMD;
            cnt_reg        <= '0;
            nbits_reg      <= '0;
            sh_reg         <= '0;
            dout           <= 1'b0;
            dout_oe        <= 1'b0;
            ifc.cmd_byte   <= '0;
            ifc.cmd_strobe <= 1'b0;
            ifc.rd_take    <= 1'b0;
            ifc.wr_word    <= '0;
            ifc.wr_strobe  <= 1'b0;
            ifc.xfer_end   <= 1'b0;
        end else if (clk_en) begin
            ifc.cmd_strobe <= 1'b0;
            ifc.rd_take    <= 1'b0;
            ifc.wr_strobe  <= 1'b0;
            ifc.xfer_end   <= 1'b0;
            if (!selected) begin
                // abort: partial writes are dropped
                ifc.xfer_end <= (state_reg != ST_CMD);
                state_reg    <= ST_CMD;
                cnt_reg      <= '0;
                dout_oe      <= 1'b0;
            end else begin
                unique case (state_reg)
                    ST_CMD: if (sclk_fall) begin
                        sh_reg  <= sh_in;
                        cnt_reg <= cnt_reg + BITCNT_W'(1);
                        if (cnt_reg == BITCNT_W'(BYTE_W - 1)) begin
                            ifc.cmd_byte   <= sh_in[BYTE_W-1:0];
                            ifc.cmd_strobe <= 1'b1;
                            cnt_reg        <= '0;
                            state_reg      <= ST_LOAD;
                        end
                    end
                    ST_LOAD: begin
                        nbits_reg <= BITCNT_W'(ifc.reg_len) * BITCNT_W'(BYTE_W);
                        sh_reg <= ifc.rd_word << (BYTE_W *
                                  (int'(LEN_3) - int'(ifc.reg_len)));
                        if (ifc.cmd_byte[CMD_DIR_BIT]) begin
                            state_reg <= ST_WR;
                        end else begin
                            ifc.rd_take <= 1'b1;
                            state_reg   <= ST_RD;
                        end
                    end
                    ST_RD: begin
                        if (sclk_rise) begin
                            dout    <= sh_reg[REG_W-1];
                            dout_oe <= 1'b1;
                            sh_reg  <= sh_reg << 1;
                        end
                        if (sclk_fall) begin
                            cnt_reg <= cnt_reg + BITCNT_W'(1);
                            if (last_bit) begin
                                dout_oe      <= 1'b0;
                                ifc.xfer_end <= 1'b1;
                                cnt_reg      <= '0;
                                state_reg    <= ST_CMD;
                            end
                        end
                    end
                    ST_WR: if (sclk_fall) begin
                        sh_reg  <= sh_in;
                        cnt_reg <= cnt_reg + BITCNT_W'(1);
                        if (last_bit) begin
                            ifc.wr_word   <= sh_in;
                            ifc.wr_strobe <= 1'b1;
                            ifc.xfer_end  <= 1'b1;
                            cnt_reg       <= '0;
                            state_reg     <= ST_CMD;
                        end
                    end
                    default: state_reg <= ST_CMD;
                endcase
            end
        end
    end

endmodule : mtr_serial
`default_nettype wire

// ===== test/mtr_regs_asserts.sv
// mtr_regs_asserts: port-level checks on the metering register front end.
// assumes: bound to mtr_regs; clk is its only clock domain.
`timescale 1ns/10ps
`default_nettype none
module mtr_regs_asserts
    import mtr_pkg::*;
(
    input wire logic                clk,
    input wire logic                resetn,
    input wire logic                clk_en,
    input wire logic                cs_n,
    input wire logic                dout_oe,
    input wire logic                irq_n,
    input wire logic                irq_oe,
    input wire logic [STATUS_W-1:0] irq_event
);
    logic seen_reg;  // some event since reset; a low irq needs a cause
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // remembers that an event pulse has arrived
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) seen_reg <= 1'b0;
        else if (|irq_event) seen_reg <= 1'b1;
    end
    irq_pair_a: assert property (irq_oe == !irq_n)
        else $error("irq pin and its enable disagree");
    irq_cause_a: assert property ($fell(irq_n) |-> seen_reg)
        else $error("irq asserted with no event recorded");
    irq_release_a: assert property ($rose(irq_n) |-> !cs_n)
        else $error("irq released outside a serial frame");
    irq_hold_a: assert property ($rose(irq_n) |=> irq_n [*8])
        else $error("irq hold ended too early");
    drive_frame_a: assert property ($rose(dout_oe) |-> !cs_n)
        else $error("data out driven while deselected");
    drive_idle_a: assert property (cs_n [*8] |-> !dout_oe)
        else $error("data out still driven after deselect");
    drive_stand_a: assert property ($rose(dout_oe) |=> (dout_oe || cs_n) [*8])
        else $error("data out dropped in mid byte");
    // a frozen enable keeps irq_n and dout_oe where they were
    freeze_hold_a: assert property (!clk_en |=> $stable(irq_n) && $stable(dout_oe))
        else $error("pins moved while clock enable low");
endmodule : mtr_regs_asserts
bind mtr_regs mtr_regs_asserts i_chk (.clk(clk), .resetn(resetn),
    .clk_en(clk_en), .cs_n(cs_n), .dout_oe(dout_oe), .irq_n(irq_n),
    .irq_oe(irq_oe), .irq_event(irq_event));
`default_nettype wire

// ===== test/mtr_host.sv
// mtr_host: behavioural serial master standing in for the host processor.
// assumes: sclk idles high, 80 ns period, and runs only inside frames.
`timescale 1ns/10ps
`default_nettype none
module mtr_host (
    output var  logic sclk,
    output var  logic cs_n,
    output var  logic din,
    input  wire logic dout
);
    initial begin
        {sclk, cs_n, din} = 3'b110;
    end
    // one frame: command byte, then nb data bytes, right justified
    task automatic xfer(input logic [7:0] cmd, input logic [23:0] wd,
                        input int nb, output logic [23:0] rd);
        logic [31:0] sh;
        // command leads, bit 6 kept clear
        sh = {cmd & 8'hbf, 24'h0} | ({8'h0, wd} << (8 * (3 - nb)));
        rd = 24'h0;
        cs_n = 1'b0;
        #40;
        for (int i = 0; i < 8 + 8 * nb; i++) begin
            din = sh[31];
            sh = sh << 1;
            #40;
            if (i >= 8) rd = {rd[22:0], dout};
            sclk = 1'b0;
            #40;
            sclk = 1'b1;
        end
        din = ~din;  // released line must not show the last bit
        #80;
        cs_n = 1'b1;
        #80;
    endtask : xfer
endmodule : mtr_host
`default_nettype wire

// ===== test/meter_irq_and_register_access_tb.sv
// meter_irq_and_register_access_tb: register, energy and irq tests.
// assumes: mtr_regs at default parameters; mtr_host drives the link.
`timescale 1ns/10ps
`default_nettype none
module meter_irq_and_register_access_tb;
    import mtr_pkg::*;
    logic clk, resetn, clk_en, sclk, cs_n, din, dout, dout_oe, irq_n, irq_oe;
    logic                    sample_valid, half_cycle_tick;
    logic [PHASES-1:0][15:0] active_power, apparent_power;
    logic [STATUS_W-1:0]     irq_event;
    logic [23:0]             rd_data;
    int                      miscompares, tests_run, cycles;
    logic                    irq_flag;  // host's edge-capture flag
    mtr_regs i_dut (.clk(clk), .resetn(resetn), .clk_en(clk_en), .sclk(sclk),
        .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe), .irq_n(irq_n),
        .irq_oe(irq_oe), .sample_valid(sample_valid),
        .active_power(active_power), .apparent_power(apparent_power),
        .half_cycle_tick(half_cycle_tick), .irq_event(irq_event));
    mtr_host i_host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
    // host senses the irq pin on its falling edge
    always @(negedge irq_n) irq_flag = 1'b1;
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // hang guard; the whole run needs well under 10000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            final_report();
        end
    end
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check
    task automatic rd(input logic [5:0] a, input int nb, input logic [23:0] e);
        i_host.xfer({2'b00, a}, 24'h0, nb, rd_data);
        check(rd_data, e);
    endtask : rd
    task automatic wr(input logic [5:0] a, input int nb, input logic [23:0] d);
        i_host.xfer({2'b10, a}, d, nb, rd_data);
    endtask : wr
    // n one-cycle pulses: 0 sample, 1 half-cycle tick, 2 event bit 0
    task automatic pulse(input int which, input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
            sample_valid = (which == 0);
            half_cycle_tick = (which == 1);
            irq_event = {15'h0, which == 2};
            @(posedge clk);
            #1;
            {sample_valid, half_cycle_tick} = 2'b00;
            irq_event = 16'h0000;
        end
    endtask : pulse
    task automatic final_report();
        if (miscompares == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report
    initial begin
        {resetn, clk_en, sample_valid, half_cycle_tick} = 4'b0100;
        irq_event = 16'h0000;
        irq_flag = 1'b0;
        active_power = {3{16'h0100}};
        apparent_power = {3{16'h0200}};
        repeat (10) @(posedge clk);
        #1 resetn = 1'b1;
        repeat (4) @(posedge clk);
        // zero after reset; reserved slot is one zero byte
        for (int a = 0; a < 5; a++) begin
            rd(6'(a), (a == 0) ? 1 : 3, 24'h0);
        end
        pulse(0, 4);
        clk_en = 1'b0;
        pulse(0, 2);  // frozen, so these two must not count
        clk_en = 1'b1;
        rd(ADDR_AE_TOTAL, 3, 24'h00000c);
        rd(ADDR_AE_RC, 3, 24'h00000c);
        rd(ADDR_AE_TOTAL, 3, 24'h000000);
        rd(ADDR_VA_TOTAL, 3, 24'h000018);
        // one phase, halved, for the total; all three for the line sum
        wr(ADDR_AE_MODE, 1, 24'h4f);
        rd(ADDR_AE_MODE, 1, 24'h4f);
        wr(ADDR_HALF_CYC, 2, 24'h0002);
        @(posedge clk);
        #1 active_power = {3{16'h1000}};
        pulse(1, 1);
        pulse(0, 4);
        pulse(1, 1);
        wr(ADDR_AE_TOTAL, 3, 24'hffffff);
        rd(ADDR_AE_TOTAL, 3, 24'h000020);
        // window restart keeps the earlier 0c00 in the line sum
        rd(ADDR_LINE_AE, 3, 24'h0000cc);
        wr(ADDR_RESERVED, 1, 24'hff);
        rd(ADDR_RESERVED, 1, 24'h0);
        // flag set while masked; unmasking pulls the pin
        pulse(2, 1);
        check(24'(irq_n), 24'h1);
        rd(ADDR_STATUS, 2, 24'h0001);
        wr(ADDR_IRQ_EN, 2, 24'h0001);
        check(24'(irq_n), 24'h0);
        check(24'(irq_flag), 24'h1);
        irq_flag = 1'b0;  // clear own flag before the status read
        fork
            rd(ADDR_STATUS_RC, 2, 24'h0001);
            begin
                #800 pulse(2, 1);
                #200 check(24'(irq_n), 24'h1);
            end
        join
        repeat (4) @(posedge clk);
        check(24'(irq_n), 24'h0);
        check(24'(irq_flag), 24'h1);
        rd(ADDR_STATUS_RC, 2, 24'h0001);
        check(24'(irq_n), 24'h1);
        final_report();
    end
endmodule : meter_irq_and_register_access_tb
`default_nettype wire
